/* File: pkg/timer_ctrl_pkg.sv */
// Constants shared by the timer control slice and its prescaler.
// Assumes a Wishbone master addressing 32-bit aligned words.
package timer_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_OC3_DATA  = 8'h00;
    localparam logic [7:0] OFF_OC3_MASK  = 8'h04;
    localparam logic [7:0] OFF_COUNT     = 8'h08;
    localparam logic [7:0] OFF_SYS_CTRL  = 8'h0C;
    localparam logic [7:0] OFF_CH_FLAGS  = 8'h10;
    localparam logic [7:0] OFF_OVF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_ACC_FLAGS = 8'h18;
    localparam logic [7:0] OFF_ACC_COUNT = 8'h1C;
    localparam logic [7:0] OFF_CH_VAL0   = 8'h20;
    localparam logic [7:0] OFF_CH_MODE   = 8'h30;
    localparam logic [7:0] OFF_PORT_DIR  = 8'h34;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h38;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h3C;
    // Field positions and sizes
    localparam int BIT_TIMER_EN   = 7;
    localparam int BIT_FAST_CLR   = 4;
    localparam int BIT_OVF_FLAG   = 7;
    localparam int BIT_ACC_OVF    = 1;
    localparam int BIT_ACC_EDGE   = 0;
    localparam int BIT_IRQ_OVF    = 0;
    localparam int BIT_IRQ_CHAN   = 1;
    localparam int BIT_IRQ_ACC    = 2;
    localparam int CHANNELS       = 4;
    localparam int IRQ_BITS       = 3;
    // Reset values and count top
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [15:0] CNT_TOP   = 16'hFFFF;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
    // Default prescale division, one tick per clock
    localparam int PRESCALE_DIV = 1;
endpackage : timer_ctrl_pkg

/* File: sim/tb_timer_counter_control_and_fast_clear.sv */
// Self-checking bench for the timer control slice.
// Assumes the far-side model drives capture and accumulator pulses.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_counter_control_and_fast_clear;
    logic        clk;
    logic        rst_n;
    logic        cyc, stb, we, test_mode, ack, irq, edge_p;
    logic [7:0]  adr;
    logic [3:0]  sel, pins, drive_en, cap, lvl;
    logic [31:0] wdat, rdat, rd, rd2;
    int          miscompares;
    int          check_count;
    int          cycles;

    timer_ctrl_top #(.PRESCALE(1)) dut (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .i_test_mode(test_mode), .i_capture_pulse(cap), .i_acc_edge(edge_p),
        .o_wb_ack(ack), .o_wb_dat(rdat), .o_timer_port_pins(pins),
        .o_port_drive_en(drive_en), .o_irq(irq));

    timer_far_side_model far (
        .i_clk_sys(clk), .i_pins(pins), .i_drive_en(drive_en),
        .o_capture_pulse(cap), .o_acc_edge(edge_p), .o_pin_level(lvl));

    // Clock at 50 MHz
    always #10 clk = ~clk;

    task automatic end_of_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle, whole words only
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    // Stop, load the count in test mode, restart with a control value
    task automatic preload(input logic [15:0] v, input logic [7:0] ctrl);
        wr(timer_ctrl_pkg::OFF_SYS_CTRL, 32'h0);
        wr(timer_ctrl_pkg::OFF_COUNT, {16'h0, v});
        wr(timer_ctrl_pkg::OFF_SYS_CTRL, {24'h0, ctrl});
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {cyc, stb, we, test_mode} = 4'h0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        cycles = 0;
        miscompares = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped place
        rd_chk(timer_ctrl_pkg::OFF_SYS_CTRL, 32'h0);
        rd_chk(8'h40, 32'h0);
        wr(timer_ctrl_pkg::OFF_OC3_DATA, 32'hA);
        rd_chk(timer_ctrl_pkg::OFF_OC3_DATA, 32'hA);
        // Count write refused in normal mode, count frozen while disabled
        wr(timer_ctrl_pkg::OFF_COUNT, 32'h1234);
        rd_chk(timer_ctrl_pkg::OFF_COUNT, 32'h0);
        rd_chk(timer_ctrl_pkg::OFF_COUNT, 32'h0);
        test_mode <= 1'b1;
        wr(timer_ctrl_pkg::OFF_COUNT, 32'h1234);
        rd_chk(timer_ctrl_pkg::OFF_COUNT, 32'h1234);
        // Running count: reads taken three cycles apart
        wr(timer_ctrl_pkg::OFF_SYS_CTRL, 32'h80);
        rd_chk(timer_ctrl_pkg::OFF_SYS_CTRL, 32'h80);
        wb(1'b0, timer_ctrl_pkg::OFF_COUNT, 32'h0, rd);
        wb(1'b0, timer_ctrl_pkg::OFF_COUNT, 32'h0, rd2);
        check(rd2 - rd, 32'h3);
        // Rollover, masked then unmasked interrupt, write-one clear
        preload(16'hFFFE, 8'h80);
        rd_chk(timer_ctrl_pkg::OFF_OC3_DATA, 32'hA);
        rd_chk(timer_ctrl_pkg::OFF_OVF_FLAGS, 32'h80);
        check({31'h0, irq}, 32'h0);
        wr(timer_ctrl_pkg::OFF_IRQ_MASK, 32'h1);
        rd_chk(timer_ctrl_pkg::OFF_IRQ_MASK, 32'h1);
        check({31'h0, irq}, 32'h1);
        rd_chk(timer_ctrl_pkg::OFF_IRQ_STAT, 32'h1);
        rd_chk(timer_ctrl_pkg::OFF_IRQ_STAT, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(timer_ctrl_pkg::OFF_OVF_FLAGS, 32'h80);
        rd_chk(timer_ctrl_pkg::OFF_OVF_FLAGS, 32'h0);
        // Fast clear: write-one ignored, count access clears overflow
        preload(16'hFFFE, 8'h90);
        rd_chk(timer_ctrl_pkg::OFF_OC3_DATA, 32'hA);
        wr(timer_ctrl_pkg::OFF_OVF_FLAGS, 32'h80);
        rd_chk(timer_ctrl_pkg::OFF_OVF_FLAGS, 32'h80);
        wb(1'b0, timer_ctrl_pkg::OFF_COUNT, 32'h0, rd);
        rd_chk(timer_ctrl_pkg::OFF_OVF_FLAGS, 32'h0);
        // Accumulator flags cleared by an accumulator count access
        far.pulse_edge();
        rd_chk(timer_ctrl_pkg::OFF_ACC_FLAGS, 32'h1);
        rd_chk(timer_ctrl_pkg::OFF_ACC_COUNT, 32'h1);
        rd_chk(timer_ctrl_pkg::OFF_ACC_FLAGS, 32'h0);
        // Capture read clears its flag under fast clear
        far.pulse_capture(4'h1);
        rd_chk(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h1);
        wb(1'b0, timer_ctrl_pkg::OFF_CH_VAL0, 32'h0, rd);
        rd_chk(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h0);
        // Normal clearing by writing ones
        wr(timer_ctrl_pkg::OFF_SYS_CTRL, 32'h80);
        far.pulse_capture(4'h4);
        rd_chk(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h4);
        wr(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h4);
        rd_chk(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h0);
        // Channel 3 and channel 0 hit together; masked data wins
        wr(timer_ctrl_pkg::OFF_CH_MODE, 32'h9);
        wr(timer_ctrl_pkg::OFF_OC3_MASK, 32'h9);
        wr(timer_ctrl_pkg::OFF_OC3_DATA, 32'h8);
        wr(timer_ctrl_pkg::OFF_CH_VAL0, 32'h10);
        wr(timer_ctrl_pkg::OFF_CH_VAL0 + 8'h0C, 32'h10);
        preload(16'h0000, 8'h90);
        check({28'h0, drive_en}, 32'h9);
        rd_chk(timer_ctrl_pkg::OFF_PORT_DIR, 32'h0);
        while (pins[3] !== 1'b1) @(posedge clk);
        check({28'h0, pins & 4'h9}, 32'h8);
        check({28'h0, lvl & 4'h9}, 32'h8);
        rd_chk(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h9);
        // Write-one to channel flags refused under fast clear
        wr(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h9);
        rd_chk(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h9);
        wr(timer_ctrl_pkg::OFF_CH_VAL0, 32'h10);
        rd_chk(timer_ctrl_pkg::OFF_CH_FLAGS, 32'h8);
        end_of_test();
    end
endmodule // tb_timer_counter_control_and_fast_clear
`default_nettype wire

/* File: sim/timer_far_side_model.sv */
// Far-side model: capture sources, accumulator input and pin loads.
// Assumes pulses are requested between bus cycles on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module timer_far_side_model (
    input  wire logic       i_clk_sys,
    input  wire logic [3:0] i_pins,
    input  wire logic [3:0] i_drive_en,
    output var  logic [3:0] o_capture_pulse,
    output var  logic       o_acc_edge,
    output var  logic [3:0] o_pin_level
);
    // Undriven pins float to the pull-up level
    assign o_pin_level = (i_pins & i_drive_en) | ~i_drive_en;

    // Quiet sources at time zero
    initial begin
        o_capture_pulse = 4'h0;
        o_acc_edge      = 1'b0;
    end

    // One-cycle capture pulse on the chosen channels
    task automatic pulse_capture(input logic [3:0] ch);
        @(posedge i_clk_sys);
        o_capture_pulse <= ch;
        @(posedge i_clk_sys);
        o_capture_pulse <= 4'h0;
    endtask

    // One-cycle accumulator input edge
    task automatic pulse_edge();
        @(posedge i_clk_sys);
        o_acc_edge <= 1'b1;
        @(posedge i_clk_sys);
        o_acc_edge <= 1'b0;
    endtask
endmodule // timer_far_side_model
`default_nettype wire

/* File: src/tick_prescaler.sv */
// Prescaler producing a one-cycle counting tick.
// Assumes one clock; the tick stops while run is low.
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler #(
    parameter int DIV = timer_ctrl_pkg::PRESCALE_DIV
) (
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_run,
    output var  logic o_tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] div_reg;
    wire          wrap = (div_reg == LAST);

    // Divider count, held while stopped
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_reg <= '0;
            o_tick  <= 1'b0;
        end else begin
            o_tick  <= i_run && wrap;
            if (i_run)
                div_reg <= wrap ? '0 : div_reg + 1'b1;
        end
    end
endmodule // tick_prescaler
`default_nettype wire

/* File: src/timer_ctrl_top.sv */
// Timer control slice: free-running count, system control,
// fast flag clearing and channel 3 port override.
// Assumes a classic Wishbone master on the same clock.
// Overview of operation
// RULE_01: Channel 3 compare copies masked data to pins
// RULE_02: Channel 3 compare beats channels 0 to 2
// RULE_03: Count register reads live 16-bit count
// RULE_04: Software reads the count as words
// RULE_05: Test write may stretch first count
// RULE_06: Count writes ignored outside test mode
// RULE_07: Enable bit stops timer, registers stay
// RULE_08: Fast clear on capture read, compare write
// RULE_09: Fast clear overflow on count access
// RULE_10: Fast clear accumulator flags on access
// RULE_11: Write-one clears only without fast clear
// RULE_12: Mask forces compare pin to output
// RULE_13: Count ticks; rollover sets overflow flag
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer_ctrl_top #(
    parameter int PRESCALE = timer_ctrl_pkg::PRESCALE_DIV
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic        i_test_mode,
    input  wire logic [3:0]  i_capture_pulse,
    input  wire logic        i_acc_edge,
    output var  logic        o_wb_ack,
    output var  logic [31:0] o_wb_dat,
    output var  logic [3:0]  o_timer_port_pins,
    output var  logic [3:0]  o_port_drive_en,
    output var  logic        o_irq
);
    localparam int N = timer_ctrl_pkg::CHANNELS;

    // Address match helper
    function automatic logic at(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic [3:0]  compare3_data_bits;
    logic [3:0]  compare3_mask_bits;
    logic [15:0] count_value_field;
    logic        timer_enable_bit;
    logic        fast_flag_clear_bit;
    logic [3:0]  chan_flag_reg;
    logic        overflow_flag;
    logic        accumulator_overflow_flag;
    logic        accumulator_edge_flag;
    logic [15:0] acc_count_reg;
    logic [15:0] chan_val_reg [N];
    logic [3:0]  chan_mode_reg;
    logic [3:0]  port_dir_reg;
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_mask_reg;
    logic        tick;

    // Bus access decode, request taken once per ack
    wire acc    = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire wr     = acc && i_wb_we;
    wire rd     = acc && !i_wb_we;
    wire lane0  = i_wb_sel[0];
    wire lane1  = i_wb_sel[1];
    wire hit_d  = at(i_wb_adr, timer_ctrl_pkg::OFF_OC3_DATA);
    wire hit_m  = at(i_wb_adr, timer_ctrl_pkg::OFF_OC3_MASK);
    wire hit_c  = at(i_wb_adr, timer_ctrl_pkg::OFF_COUNT);
    wire hit_s  = at(i_wb_adr, timer_ctrl_pkg::OFF_SYS_CTRL);
    wire hit_cf = at(i_wb_adr, timer_ctrl_pkg::OFF_CH_FLAGS);
    wire hit_of = at(i_wb_adr, timer_ctrl_pkg::OFF_OVF_FLAGS);
    wire hit_af = at(i_wb_adr, timer_ctrl_pkg::OFF_ACC_FLAGS);
    wire hit_ac = at(i_wb_adr, timer_ctrl_pkg::OFF_ACC_COUNT);
    wire hit_md = at(i_wb_adr, timer_ctrl_pkg::OFF_CH_MODE);
    wire hit_dr = at(i_wb_adr, timer_ctrl_pkg::OFF_PORT_DIR);
    wire hit_is = at(i_wb_adr, timer_ctrl_pkg::OFF_IRQ_STAT);
    wire hit_im = at(i_wb_adr, timer_ctrl_pkg::OFF_IRQ_MASK);
    wire hit_cv = (i_wb_adr[7:4] == timer_ctrl_pkg::OFF_CH_VAL0[7:4]) && (i_wb_adr[1:0] == 2'h0);
    wire [1:0] cv_idx = i_wb_adr[3:2];

    // Counter enable and rollover
    wire        run     = timer_enable_bit;                                       // RULE_07
    wire        step    = run && tick;                                            // RULE_13
    wire [15:0] cnt_inc = count_value_field + 16'h0001;
    wire        roll    = step && (count_value_field == timer_ctrl_pkg::CNT_TOP); // RULE_13
    wire        cnt_wr  = wr && hit_c && i_test_mode;                             // RULE_06

    tick_prescaler #(
        .DIV       (PRESCALE)
    ) u_prescaler (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_run     (run),
        .o_tick    (tick)
    );

    // Compare hits and channel 3 override
    logic [3:0] cmp_hit;
    logic [3:0] cap_hit;
    logic [3:0] cv_sel;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chan
            assign cmp_hit[g] = step && chan_mode_reg[g] && (cnt_inc == chan_val_reg[g]);
            assign cap_hit[g] = run && !chan_mode_reg[g] && i_capture_pulse[g];
            assign cv_sel[g]  = hit_cv && (cv_idx == 2'(g));
        end
    endgenerate
    wire [3:0] oc3_ovr  = {4{cmp_hit[3]}} & compare3_mask_bits;               // RULE_02
    wire [3:0] pin_tog  = (cmp_hit[2:0] == 3'h0) ? 4'h0 : {1'b0, cmp_hit[2:0]};
    wire [3:0] pin_next = (oc3_ovr & compare3_data_bits)                      // RULE_01
                        | (~oc3_ovr & (o_timer_port_pins ^ pin_tog));         // RULE_02
    wire [3:0] forced_out = compare3_mask_bits & chan_mode_reg;               // RULE_12
    wire [3:0] drv_next   = port_dir_reg | forced_out;                        // RULE_12

    // Channel flag set and clear sources
    wire [3:0] ch_set     = cmp_hit | cap_hit;
    wire [3:0] ch_fast    = {4{fast_flag_clear_bit}} & cv_sel
                          & ((wr ? chan_mode_reg : 4'h0) | (rd ? ~chan_mode_reg : 4'h0)); // RULE_08
    wire       slow_w1c   = wr && lane0 && !fast_flag_clear_bit;              // RULE_11
    wire [3:0] ch_w1c     = (slow_w1c && hit_cf) ? i_wb_dat[3:0] : 4'h0;      // RULE_11
    wire [3:0] ch_clr     = ch_fast | ch_w1c;
    wire [3:0] ch_fast_only = ch_fast & ~ch_set;                              // RULE_08
    wire       ovf_clr    = (fast_flag_clear_bit && acc && hit_c)             // RULE_09
                          || (slow_w1c && hit_of && i_wb_dat[timer_ctrl_pkg::BIT_OVF_FLAG]);
    wire       acc_fast   = fast_flag_clear_bit && acc && hit_ac;             // RULE_10
    wire       aovf_clr   = acc_fast || (slow_w1c && hit_af && i_wb_dat[timer_ctrl_pkg::BIT_ACC_OVF]);
    wire       aedg_clr   = acc_fast || (slow_w1c && hit_af && i_wb_dat[timer_ctrl_pkg::BIT_ACC_EDGE]);
    wire [15:0] acc_inc   = acc_count_reg + 16'h0001;
    wire        acc_step  = run && i_acc_edge;
    wire        acc_roll  = acc_step && (acc_count_reg == timer_ctrl_pkg::CNT_TOP);
    wire [2:0]  irq_set   = {acc_step, |ch_set, roll};
    wire [2:0]  irq_clr   = (rd && hit_is) ? 3'h7 : 3'h0;

    // Read data selection
    wire [7:0]  sys_rd = {timer_enable_bit, 2'h0, fast_flag_clear_bit, 4'h0};
    wire [7:0]  ovf_rd = {overflow_flag, 7'h00};
    wire [7:0]  afl_rd = {6'h00, accumulator_overflow_flag, accumulator_edge_flag};
    wire [15:0] cv_rd  = chan_val_reg[cv_idx];
    wire [15:0] rd_lo  = hit_d  ? {12'h000, compare3_data_bits} :
                         hit_m  ? {12'h000, compare3_mask_bits} :
                         hit_c  ? count_value_field :              // RULE_03
                         hit_s  ? {8'h00, sys_rd} :
                         hit_cf ? {12'h000, chan_flag_reg} :
                         hit_of ? {8'h00, ovf_rd} :
                         hit_af ? {8'h00, afl_rd} :
                         hit_ac ? acc_count_reg :
                         hit_cv ? cv_rd :
                         hit_md ? {12'h000, chan_mode_reg} :
                         hit_dr ? {12'h000, port_dir_reg} :
                         hit_is ? {13'h0000, irq_stat_reg} :
                         hit_im ? {13'h0000, irq_mask_reg} : timer_ctrl_pkg::RST_WORD;

    // Bus answer, one cycle after the request
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= timer_ctrl_pkg::RD_ZERO;
        end else begin
            o_wb_ack <= acc;
            o_wb_dat <= rd ? {16'h0000, rd_lo} : timer_ctrl_pkg::RD_ZERO;
        end
    end

    // Software-owned control registers
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            compare3_data_bits  <= 4'h0;
            compare3_mask_bits  <= 4'h0;
            timer_enable_bit    <= 1'b0;
            fast_flag_clear_bit <= 1'b0;
            chan_mode_reg       <= 4'h0;
            port_dir_reg        <= 4'h0;
            irq_mask_reg        <= 3'h0;
        end else if (wr && lane0) begin
            if (hit_d)  compare3_data_bits  <= i_wb_dat[3:0];  // RULE_01
            if (hit_m)  compare3_mask_bits  <= i_wb_dat[3:0];
            if (hit_s)  timer_enable_bit    <= i_wb_dat[timer_ctrl_pkg::BIT_TIMER_EN];
            if (hit_s)  fast_flag_clear_bit <= i_wb_dat[timer_ctrl_pkg::BIT_FAST_CLR];
            if (hit_md) chan_mode_reg       <= i_wb_dat[3:0];
            if (hit_dr) port_dir_reg        <= i_wb_dat[3:0];
            if (hit_im) irq_mask_reg        <= i_wb_dat[2:0];
        end
    end

    // Free-running count; test-mode writes load it unsynchronised to the tick
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n)
            count_value_field <= timer_ctrl_pkg::RST_WORD;
        else if (cnt_wr) begin                                                 // RULE_05
            if (lane0) count_value_field[7:0]  <= i_wb_dat[7:0];
            if (lane1) count_value_field[15:8] <= i_wb_dat[15:8];
        end else if (step)
            count_value_field <= cnt_inc;                                      // RULE_13
    end

    // Channel values: compare written by software, capture latched
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int k = 0; k < N; k++)
                chan_val_reg[k] <= timer_ctrl_pkg::RST_WORD;
        end else begin
            for (int k = 0; k < N; k++) begin
                if (cap_hit[k])
                    chan_val_reg[k] <= count_value_field;
                else if (wr && cv_sel[k]) begin
                    if (lane0) chan_val_reg[k][7:0]  <= i_wb_dat[7:0];
                    if (lane1) chan_val_reg[k][15:8] <= i_wb_dat[15:8];
                end
            end
        end
    end

    // Accumulator count, cleared or loaded by software
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n)
            acc_count_reg <= timer_ctrl_pkg::RST_WORD;
        else if (wr && hit_ac) begin
            if (lane0) acc_count_reg[7:0]  <= i_wb_dat[7:0];
            if (lane1) acc_count_reg[15:8] <= i_wb_dat[15:8];
        end else if (acc_step)
            acc_count_reg <= acc_inc;
    end

    // Sticky flags, a set beats a clear in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            chan_flag_reg             <= 4'h0;
            overflow_flag             <= 1'b0;
            accumulator_overflow_flag <= 1'b0;
            accumulator_edge_flag     <= 1'b0;
            irq_stat_reg              <= 3'h0;
        end else begin
            chan_flag_reg             <= (chan_flag_reg & ~ch_clr) | ch_set;         // RULE_08
            overflow_flag             <= (overflow_flag && !ovf_clr) || roll;        // RULE_09
            accumulator_overflow_flag <= (accumulator_overflow_flag && !aovf_clr) || acc_roll; // RULE_10
            accumulator_edge_flag     <= (accumulator_edge_flag && !aedg_clr) || acc_step;
            irq_stat_reg              <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end

    // Port pins, drive enables and interrupt line
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_timer_port_pins <= 4'h0;
            o_port_drive_en   <= 4'h0;
            o_irq             <= 1'b0;
        end else begin
            o_timer_port_pins <= pin_next;                   // RULE_01
            o_port_drive_en   <= drv_next;                   // RULE_12
            o_irq             <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Checks on the logic above
    AST_OC3_OVERRIDE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_02
        cmp_hit[3] |=> ((o_timer_port_pins & $past(compare3_mask_bits))
                        == ($past(compare3_data_bits) & $past(compare3_mask_bits))))
        else $error("channel 3 override not applied");

    AST_COUNT_READ: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_03
        (rd && hit_c) |=> (o_wb_ack && o_wb_dat[15:0] == $past(count_value_field)))
        else $error("count read mismatch");

    AST_COUNT_WR_IGNORED: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_06
        (wr && hit_c && !i_test_mode && !step) |=> $stable(count_value_field))
        else $error("count changed by normal-mode write");

    AST_TEST_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_05
        (cnt_wr && i_wb_sel[1:0] == 2'h3) |=> count_value_field == $past(i_wb_dat[15:0]))
        else $error("test-mode load failed");

    AST_DISABLED_STOP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_07
        (!timer_enable_bit && !cnt_wr)[*2] |=> $stable(count_value_field))
        else $error("count moved while disabled");

    AST_ROLLOVER: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_13
        (roll && !cnt_wr) |=> (overflow_flag && count_value_field == timer_ctrl_pkg::RST_WORD))
        else $error("rollover did not set overflow");

    AST_FAST_OVF_CLR: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_09
        (fast_flag_clear_bit && acc && hit_c && !roll) |=> !overflow_flag)
        else $error("overflow flag not fast cleared");

    AST_FAST_ACC_CLR: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_10
        (acc_fast && !acc_step) |=> (!accumulator_overflow_flag && !accumulator_edge_flag))
        else $error("accumulator flags not fast cleared");

    AST_FAST_CHAN_CLR: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_08
        (ch_fast_only != 4'h0) |=> ((chan_flag_reg & $past(ch_fast_only)) == 4'h0))
        else $error("channel flag not fast cleared");

    AST_W1C_BLOCKED: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_11
        (fast_flag_clear_bit && wr && hit_cf) |=> ((chan_flag_reg & $past(chan_flag_reg)) == $past(chan_flag_reg)))
        else $error("flag cleared by write while fast clear set");

    AST_FORCE_OUTPUT: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_12
        1'b1 |=> ((o_port_drive_en & $past(forced_out)) == $past(forced_out)))
        else $error("masked compare pin not driven");

    COV_OC3_HIT:   cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) cmp_hit[3] && compare3_mask_bits != 4'h0);
    COV_ROLLOVER:  cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) roll);
    COV_FAST_CLR:  cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) fast_flag_clear_bit && acc && hit_c && overflow_flag);
    COV_IRQ:       cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) o_irq);
endmodule // timer_ctrl_top
`default_nettype wire
